// ==== hw/ctb_tx_buffers.sv ====
`timescale 1ns/10ps
`default_nettype none
module ctb_tx_buffers (
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             tx_valid_out,
    input  wire logic        tx_ready_in,
    output logic      [1:0]  tx_buf_out,
    output logic      [28:0] tx_id_out,
    output logic             tx_ext_out,
    output logic             tx_rtr_out,
    output logic      [3:0]  tx_dlc_out,
    output logic      [63:0] tx_data_out,
    output logic             tx_abort_out,
    input  wire logic        tx_done_in,
    input  wire logic        tx_arb_lost_in,
    input  wire logic        tx_bus_err_in,
    input  wire logic [3:0]  tec_add_in,
    input  wire logic        tec_dec_in,
    input  wire logic        recessive_run_in,
    input  wire logic [7:0]  rx_err_count_in,
    input  wire logic        rx0_overflow_in,
    input  wire logic        rx1_overflow_in
);
    // ------------------------------------------------------------------
    // State and bus decode
    // ------------------------------------------------------------------
    ctb_pkg::ctb_state_t s_q;
    ctb_pkg::ctb_state_t s_d;
    logic                setup_ph;
    logic                wr_acc;
    logic                in_buf;
    logic [1:0]          bsel;
    logic [5:0]          offs;
    logic                hit;
    logic [31:0]         rd_val;
    logic [8:0]          rec9;
    logic [7:0]          comm;
    logic [2:0]          icode;
    logic [1:0]          pick;
    logic                any_pend;
    logic                bus_off;

    // Zero-wait slave: read data is captured in the setup cycle.
    assign setup_ph = psel_in & ~penable_in;
    assign wr_acc   = psel_in & penable_in & pwrite_in;
    assign in_buf   = (paddr_in[11:6] >= ctb_pkg::BLK_FIRST) &&
                      (paddr_in[11:6] <= ctb_pkg::BLK_LAST);
    assign bsel     = paddr_in[7:6] - 2'd1;
    assign offs     = paddr_in[5:0];

    // Error-state flags comm[5:0] are decoded from the live counters every cycle; comm[7:6] are the stored overflow flags.
    assign rec9    = {1'b0, rx_err_count_in};
    assign bus_off = s_q.tec > ctb_pkg::TEC_BUS_OFF;
    assign comm[ctb_pkg::CS_RX0_OVF] = s_q.rx0_ovf;
    assign comm[ctb_pkg::CS_RX1_OVF] = s_q.rx1_ovf;
    assign comm[5] = bus_off;
    assign comm[4] = s_q.tec > ctb_pkg::PASSIVE_LIMIT;
    assign comm[3] = rec9 > ctb_pkg::PASSIVE_LIMIT;
    assign comm[2] = (s_q.tec > ctb_pkg::WARN_LIMIT) &&
                     (s_q.tec <= ctb_pkg::PASSIVE_LIMIT);
    assign comm[1] = (rec9 > ctb_pkg::WARN_LIMIT) &&
                     (rec9 <= ctb_pkg::PASSIVE_LIMIT);
    assign comm[0] = comm[2] | comm[1];

    // Completion code, buffer 0 reported first.
    assign icode = s_q.sent[0] ? ctb_pkg::ICODE_TX0 :
                   s_q.sent[1] ? ctb_pkg::ICODE_TX1 :
                   s_q.sent[2] ? ctb_pkg::ICODE_TX2 : ctb_pkg::ICODE_NONE;

    // Read data and frame outputs come from registered state; pslverr_out is decoded combinationally.
    assign prdata_out   = s_q.rdata;
    assign pready_out   = 1'b1;
    assign pslverr_out  = psel_in & penable_in & ~hit;
    assign tx_valid_out = (s_q.fsm == ctb_pkg::ST_OFFER);
    assign tx_buf_out   = s_q.cur;
    assign tx_id_out    = s_q.f_id;
    assign tx_ext_out   = s_q.f_ext;
    assign tx_rtr_out   = s_q.f_rtr;
    assign tx_dlc_out   = s_q.f_dlc;
    assign tx_data_out  = s_q.f_data;
    assign tx_abort_out = s_q.abort_p;

    // ------------------------------------------------------------------
    // Arbitration among pending buffers
    // ------------------------------------------------------------------
    // Scanning downward with >= lets the lower number win a tie.
    always_comb begin
        pick     = 2'd0;
        any_pend = 1'b0;
        for (int i = 2; i >= 0; i--) begin
            if (s_q.bctl[i][ctb_pkg::BC_REQ] &&
                (!any_pend || s_q.bctl[i][1:0] >= s_q.bctl[pick][1:0])) begin
                pick     = 2'(i);
                any_pend = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------------
    always_comb begin
        hit    = 1'b0;
        rd_val = 32'h0000_0000;
        if (paddr_in[1:0] == 2'b00) begin
            if (!in_buf) begin
                hit = 1'b1;
                unique case (paddr_in)
                    ctb_pkg::ADDR_CONTROL: rd_val[7:0] = s_q.control;
                    ctb_pkg::ADDR_STATUS:  rd_val[3:1] = icode;
                    ctb_pkg::ADDR_COMM:    rd_val[7:0] = comm;
                    ctb_pkg::ADDR_TEC:     rd_val[7:0] = s_q.tec[7:0];
                    default:               hit = 1'b0;
                endcase
            end else if (offs[ctb_pkg::OFS_DATA_BIT]) begin
                hit         = 1'b1;
                rd_val[7:0] = s_q.data[bsel][offs[4:2]];
            end else begin
                hit = 1'b1;
                unique case (offs)
                    ctb_pkg::OFS_CTRL: rd_val[7:0] = s_q.bctl[bsel];
                    ctb_pkg::OFS_SIDH: rd_val[7:0] = s_q.sidh[bsel];
                    ctb_pkg::OFS_SIDL: rd_val[7:0] = s_q.sidl[bsel];
                    ctb_pkg::OFS_EIDH: rd_val[7:0] = s_q.eidh[bsel];
                    ctb_pkg::OFS_EIDL: rd_val[7:0] = s_q.eidl[bsel];
                    ctb_pkg::OFS_DLC:  rd_val[7:0] = s_q.dlc[bsel];
                    default:           hit = 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Counter and sequencer events are applied first, then software writes, then
    // overflow sets and abort-all, so a later stage only overrides what it must.
    always_comb begin
        s_d         = s_q;
        s_d.abort_p = 1'b0;
        if (setup_ph) begin
            s_d.rdata = rd_val;
        end
        // Error counter, frozen while bus-off until recovery clears it.
        if (!bus_off) begin
            if (({5'h00, tec_add_in} + s_q.tec) > ctb_pkg::TEC_CEILING) begin
                s_d.tec = ctb_pkg::TEC_CEILING;
            end else if (tec_add_in != 4'h0) begin
                s_d.tec = s_q.tec + {5'h00, tec_add_in};
            end else if (tec_dec_in && s_q.tec != ctb_pkg::TEC_RST) begin
                s_d.tec = s_q.tec - 9'h001;
            end
            s_d.recov = 7'h00;
        end else if (recessive_run_in) begin
            if (s_q.recov == ctb_pkg::RECOVERY_LAST) begin
                s_d.tec   = ctb_pkg::TEC_RST;
                s_d.recov = 7'h00;
            end else begin
                s_d.recov = s_q.recov + 7'h01;
            end
        end
        // Transmit sequencer.
        unique case (s_q.fsm)
            ctb_pkg::ST_IDLE: begin
                if (any_pend && !bus_off) begin
                    s_d.fsm   = ctb_pkg::ST_OFFER;
                    s_d.cur   = pick;
                    s_d.f_ext = s_q.sidl[pick][ctb_pkg::SIDL_EXT];
                    if (s_q.sidl[pick][ctb_pkg::SIDL_EXT]) begin
                        s_d.f_id = {s_q.sidh[pick], s_q.sidl[pick][7:5],
                                    s_q.sidl[pick][1:0], s_q.eidh[pick],
                                    s_q.eidl[pick]};
                    end else begin
                        s_d.f_id = {18'h00000, s_q.sidh[pick],
                                    s_q.sidl[pick][7:5]};
                    end
                    s_d.f_rtr  = s_q.dlc[pick][ctb_pkg::DLC_RTR];
                    s_d.f_dlc  = s_q.dlc[pick][3:0];
                    s_d.f_data = s_q.data[pick];
                end
            end
            ctb_pkg::ST_OFFER: begin
                if (tx_ready_in) begin
                    s_d.fsm = ctb_pkg::ST_SEND;
                end
            end
            ctb_pkg::ST_SEND: begin
                if (tx_done_in) begin
                    s_d.bctl[s_q.cur][ctb_pkg::BC_REQ] = 1'b0;
                    s_d.sent[s_q.cur] = 1'b1;
                    s_d.fsm = ctb_pkg::ST_IDLE;
                end else if (tx_arb_lost_in) begin
                    s_d.bctl[s_q.cur][ctb_pkg::BC_LARB] = 1'b1;
                    s_d.fsm = ctb_pkg::ST_IDLE;
                end else if (tx_bus_err_in) begin
                    s_d.bctl[s_q.cur][ctb_pkg::BC_BERR] = 1'b1;
                    s_d.fsm = ctb_pkg::ST_IDLE;
                end
            end
            default: s_d.fsm = ctb_pkg::ST_IDLE;
        endcase
        // Software writes; overflow clears lose to a same-cycle overflow.
        if (wr_acc && hit) begin
            if (!in_buf) begin
                if (paddr_in == ctb_pkg::ADDR_CONTROL) begin
                    s_d.control = pwdata_in[7:0] & ctb_pkg::CONTROL_MASK;
                end
                if (paddr_in == ctb_pkg::ADDR_COMM) begin
                    s_d.rx0_ovf = s_q.rx0_ovf & pwdata_in[ctb_pkg::CS_RX0_OVF];
                    s_d.rx1_ovf = s_q.rx1_ovf & pwdata_in[ctb_pkg::CS_RX1_OVF];
                end
            end else if (offs[ctb_pkg::OFS_DATA_BIT]) begin
                s_d.data[bsel][offs[4:2]] = pwdata_in[7:0];
            end else begin
                unique case (offs)
                    ctb_pkg::OFS_CTRL: begin
                        s_d.bctl[bsel][1:0] = pwdata_in[1:0];
                        if (pwdata_in[ctb_pkg::BC_REQ] && !s_q.bctl[bsel][ctb_pkg::BC_REQ]) begin
                            s_d.bctl[bsel][6:3] = 4'h1;
                            s_d.sent[bsel]      = 1'b0;
                        end else if (!pwdata_in[ctb_pkg::BC_REQ] &&
                                     s_q.bctl[bsel][ctb_pkg::BC_REQ]) begin
                            s_d.bctl[bsel][ctb_pkg::BC_REQ]     = 1'b0;
                            s_d.bctl[bsel][ctb_pkg::BC_ABORTED] = 1'b1;
                            if (s_q.fsm != ctb_pkg::ST_IDLE && s_q.cur == bsel) begin
                                s_d.abort_p = (s_q.fsm == ctb_pkg::ST_SEND);
                                s_d.fsm     = ctb_pkg::ST_IDLE;
                            end
                        end
                    end
                    ctb_pkg::OFS_SIDH: s_d.sidh[bsel] = pwdata_in[7:0];
                    ctb_pkg::OFS_SIDL: s_d.sidl[bsel] = pwdata_in[7:0] & ctb_pkg::SIDL_MASK;
                    ctb_pkg::OFS_EIDH: s_d.eidh[bsel] = pwdata_in[7:0];
                    ctb_pkg::OFS_EIDL: s_d.eidl[bsel] = pwdata_in[7:0];
                    ctb_pkg::OFS_DLC:  s_d.dlc[bsel]  = pwdata_in[7:0] & ctb_pkg::DLC_MASK;
                    default:           s_d.dlc[bsel]  = s_q.dlc[bsel];
                endcase
            end
        end
        s_d.rx0_ovf = s_d.rx0_ovf | rx0_overflow_in;
        s_d.rx1_ovf = s_d.rx1_ovf | rx1_overflow_in;
        // Abort-all keeps draining requests for as long as the bit is set.
        // Testing the next value catches a request written in this very cycle
        // and spares one that has just completed, since success cleared it.
        if (s_q.control[ctb_pkg::CTL_ABORT_ALL]) begin
            for (int i = 0; i < 3; i++) begin
                if (s_d.bctl[i][ctb_pkg::BC_REQ]) begin
                    s_d.bctl[i][ctb_pkg::BC_REQ]     = 1'b0;
                    s_d.bctl[i][ctb_pkg::BC_ABORTED] = 1'b1;
                end
            end
            if (s_q.fsm != ctb_pkg::ST_IDLE) begin
                s_d.abort_p = (s_q.fsm == ctb_pkg::ST_SEND) && !tx_done_in;
                s_d.fsm     = ctb_pkg::ST_IDLE;
            end
        end
    end

    // All state resets to constants, data bytes included.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q         <= '0;
            s_q.fsm     <= ctb_pkg::ST_IDLE;
            s_q.control <= ctb_pkg::CONTROL_RST;
            s_q.tec     <= ctb_pkg::TEC_RST;
            s_q.bctl    <= {3{ctb_pkg::BCTL_RST}};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    property p_ovf_sticky;
        s_q.rx0_ovf && !(wr_acc && paddr_in == ctb_pkg::ADDR_COMM) |=> s_q.rx0_ovf;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
    property p_bus_off;
        comm[5] == (s_q.tec > 9'h0ff);
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus-off flag wrong");
    property p_passive;
        (comm[4] == (s_q.tec > 9'h07f)) && (comm[3] == (rx_err_count_in > 8'h7f));
    endproperty
    a_passive: assert property (p_passive) else $error("passive flag wrong");
    property p_warn;
        comm[1] == (rx_err_count_in > 8'h5f && rx_err_count_in < 8'h80) &&
        comm[2] == (s_q.tec > 9'h05f && s_q.tec < 9'h080) && comm[0] == (comm[1] | comm[2]);
    endproperty
    a_warn: assert property (p_warn) else $error("warning flags wrong");
    property p_req_set;
        wr_acc && in_buf && offs == ctb_pkg::OFS_CTRL && pwdata_in[3] &&
        !s_q.bctl[bsel][3] && !s_q.control[4] |=> s_q.bctl[$past(bsel)][6:3] == 4'h1;
    endproperty
    a_req_set: assert property (p_req_set) else $error("request set failed");
    property p_done;
        s_q.fsm == ctb_pkg::ST_SEND && tx_done_in |=> !s_q.bctl[$past(s_q.cur)][3] &&
        s_q.fsm == ctb_pkg::ST_IDLE;
    endproperty
    a_done: assert property (p_done) else $error("request kept after success");
    property p_arb;
        s_q.fsm == ctb_pkg::ST_SEND && !tx_done_in && tx_arb_lost_in
        |=> s_q.bctl[$past(s_q.cur)][5];
    endproperty
    a_arb: assert property (p_arb) else $error("arbitration loss not flagged");
    property p_recover;
        bus_off && recessive_run_in && s_q.recov == 7'h7f |=> s_q.tec == 9'h000;
    endproperty
    a_recover: assert property (p_recover) else $error("recovery did not clear count");
    property p_abort_all;
        s_q.control[4] ##1 s_q.control[4] |-> s_q.bctl[0][3] == 1'b0 &&
        s_q.bctl[1][3] == 1'b0 && s_q.bctl[2][3] == 1'b0;
    endproperty
    a_abort_all: assert property (p_abort_all) else $error("request survived abort-all");
    property p_offer_ext;
        s_q.fsm == ctb_pkg::ST_IDLE ##1 s_q.fsm == ctb_pkg::ST_OFFER && !s_q.f_ext
        |-> s_q.f_id[28:11] == 18'h00000;
    endproperty
    a_offer_ext: assert property (p_offer_ext) else $error("standard id has extended bits");

    c_sent: cover property (s_q.fsm == ctb_pkg::ST_SEND ##1 s_q.sent != 3'h0);
    c_abort: cover property (tx_abort_out);
    c_bus_off: cover property (bus_off ##[1:1000] !bus_off);
endmodule
`default_nettype wire

// ==== hw/ctb_pkg.sv ====
`default_nettype none
package ctb_pkg;
    // ------------------------------------------------------------------
    // Register map, byte addresses on the APB bus.
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_COMM    = 12'h008;
    localparam logic [11:0] ADDR_TEC     = 12'h00c;
    // Buffer n occupies block n+1 of 64 bytes (paddr[11:6]).
    localparam logic [5:0]  BLK_FIRST    = 6'h01;
    localparam logic [5:0]  BLK_LAST     = 6'h03;
    localparam logic [5:0]  OFS_CTRL     = 6'h00;
    localparam logic [5:0]  OFS_SIDH     = 6'h04;
    localparam logic [5:0]  OFS_SIDL     = 6'h08;
    localparam logic [5:0]  OFS_EIDH     = 6'h0c;
    localparam logic [5:0]  OFS_EIDL     = 6'h10;
    localparam logic [5:0]  OFS_DLC      = 6'h14;
    localparam int          OFS_DATA_BIT = 5;
    // ------------------------------------------------------------------
    // Field positions and write masks.
    // ------------------------------------------------------------------
    localparam int          CTL_ABORT_ALL = 4;
    localparam logic [7:0]  CONTROL_MASK  = 8'h1e;
    localparam int          ST_ICODE_LSB  = 1;
    localparam int          BC_ABORTED    = 6;
    localparam int          BC_LARB       = 5;
    localparam int          BC_BERR       = 4;
    localparam int          BC_REQ        = 3;
    localparam int          BC_PRI_LSB    = 0;
    localparam logic [7:0]  SIDL_MASK     = 8'heb;
    localparam int          SIDL_EXT      = 3;
    localparam logic [7:0]  DLC_MASK      = 8'h4f;
    localparam int          DLC_RTR       = 6;
    localparam int          CS_RX0_OVF    = 7;
    localparam int          CS_RX1_OVF    = 6;
    // ------------------------------------------------------------------
    // Reset values, thresholds and codes.
    // ------------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RST   = 8'h00;
    localparam logic [7:0]  BCTL_RST      = 8'h00;
    localparam logic [8:0]  TEC_RST       = 9'h000;
    localparam logic [8:0]  TEC_BUS_OFF   = 9'h0ff;
    localparam logic [8:0]  TEC_CEILING   = 9'h100;
    localparam logic [8:0]  PASSIVE_LIMIT = 9'h07f;
    localparam logic [8:0]  WARN_LIMIT    = 9'h05f;
    localparam logic [6:0]  RECOVERY_LAST = 7'h7f;
    localparam logic [2:0]  ICODE_NONE    = 3'h0;
    localparam logic [2:0]  ICODE_TX0     = 3'h4;
    localparam logic [2:0]  ICODE_TX1     = 3'h3;
    localparam logic [2:0]  ICODE_TX2     = 3'h2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_OFFER = 2'b01,
        ST_SEND  = 2'b10
    } ctb_fsm_t;

    typedef struct packed {
        ctb_fsm_t                  fsm;
        logic [1:0]                cur;
        logic [7:0]                control;
        logic                      rx0_ovf;
        logic                      rx1_ovf;
        logic [8:0]                tec;
        logic [6:0]                recov;
        logic [2:0]                sent;
        logic [2:0][7:0]           bctl;
        logic [2:0][7:0]           sidh;
        logic [2:0][7:0]           sidl;
        logic [2:0][7:0]           eidh;
        logic [2:0][7:0]           eidl;
        logic [2:0][7:0]           dlc;
        logic [2:0][7:0][7:0]      data;
        logic [28:0]               f_id;
        logic                      f_ext;
        logic                      f_rtr;
        logic [3:0]                f_dlc;
        logic [63:0]               f_data;
        logic                      abort_p;
        logic [31:0]               rdata;
    } ctb_state_t;
endpackage
`default_nettype wire

// ==== dv/ctb_engine_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Stand-in engine: takes an offer a cycle late and reports a result ten cycles on.
module ctb_engine_model (
    input  wire logic       clock_in,
    input  wire logic       rstn_in,
    input  wire logic       valid_in,
    input  wire logic       abort_in,
    input  wire logic [1:0] result_in,
    output logic            ready_out,
    output logic            done_out,
    output logic            lost_out,
    output logic            err_out
);
    logic       busy_q;
    logic [3:0] wait_q;
    // The long send time leaves room for a software abort in mid-frame.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {busy_q, wait_q, ready_out, done_out, lost_out, err_out} <= '0;
        end else begin
            {done_out, lost_out, err_out} <= 3'h0;
            ready_out <= valid_in && !busy_q && !ready_out;
            if (busy_q && abort_in) begin
                busy_q <= 1'b0;
            end else if (busy_q && wait_q == 4'h0) begin
                busy_q <= 1'b0;
                {done_out, lost_out, err_out} <= 3'h4 >> result_in;
            end else if (busy_q) begin
                wait_q <= wait_q - 4'h1;
            end else if (valid_in && ready_out) begin
                {busy_q, wait_q} <= {1'b1, 4'h9};
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/ctb_tx_buffers_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module ctb_tx_buffers_tb_top;
    logic clock_in = 1'b0, rstn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic pready_out, pslverr_out, tx_valid_out, tx_ready_in, tx_ext_out, tx_rtr_out, se;
    logic tx_abort_out, tx_done_in, tx_arb_lost_in, tx_bus_err_in;
    logic [1:0] tx_buf_out, result = 2'h0;
    logic [28:0] tx_id_out;
    logic [3:0] tx_dlc_out, tec_add_in = 4'h0;
    logic [63:0] tx_data_out;
    logic tec_dec_in = 1'b0, recessive_run_in = 1'b0, rx0_overflow_in = 1'b0, rx1_overflow_in = 1'b0;
    logic [7:0] rx_err_count_in = 8'h00;
    int err_total = 0, check_count = 0, cyc = 0;
    always #12.5 clock_in = ~clock_in;
    ctb_tx_buffers ctb_tx_buffers_inst (.clock_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .tx_valid_out,
        .tx_ready_in, .tx_buf_out, .tx_id_out, .tx_ext_out, .tx_rtr_out, .tx_dlc_out,
        .tx_data_out, .tx_abort_out, .tx_done_in, .tx_arb_lost_in, .tx_bus_err_in, .tec_add_in,
        .tec_dec_in, .recessive_run_in, .rx_err_count_in, .rx0_overflow_in, .rx1_overflow_in);
    ctb_engine_model ctb_engine_model_inst (.clock_in, .rstn_in, .valid_in(tx_valid_out),
        .abort_in(tx_abort_out), .result_in(result), .ready_out(tx_ready_in),
        .done_out(tx_done_in), .lost_out(tx_arb_lost_in), .err_out(tx_bus_err_in));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // One APB transfer; an idle edge after it keeps drivers from colliding.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, 24'h0, d};
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        {rd, se} = {prdata_out, pslverr_out};
        {psel_in, penable_in} <= 2'h0;
        @(posedge clock_in);
    endtask
    task automatic poll(input int b, input logic v);
        for (int i = 0; i < 30; i++) begin
            apb(1'b0, 12'h040, 8'h00);
            if (rd[b] === v) break;
        end
    endtask
    task automatic t_frame();
        apb(1'b1, 12'h084, 8'ha5);
        apb(1'b1, 12'h088, 8'h6b);
        apb(1'b1, 12'h08c, 8'h3c);
        apb(1'b1, 12'h090, 8'hd2);
        apb(1'b1, 12'h094, 8'h48);
        apb(1'b1, 12'h0bc, 8'h77);
        apb(1'b1, 12'h080, 8'h0a);
        for (int i = 0; i < 40 && tx_valid_out !== 1'b1; i++) @(posedge clock_in);
        chk("id", {3'h0, 8'ha5, 3'h3, 2'h3, 16'h3cd2}, {3'h0, tx_id_out});
        chk("kind", 32'h78, {24'h0, tx_buf_out, tx_ext_out, tx_rtr_out, tx_dlc_out});
        chk("byte7", 32'h77, {24'h0, tx_data_out[63:56]});
        for (int i = 0; i < 30 && tx_valid_out === 1'b1; i++) @(posedge clock_in);
        for (int i = 0; i < 20; i++) apb(1'b0, 12'h080, 8'h00);
        chk("ctrl1", 32'h02, rd);
        apb(1'b0, ctb_pkg::ADDR_STATUS, 8'h00);
        chk("code", 32'h06, rd);
        apb(1'b1, ctb_pkg::ADDR_CONTROL, {4'h0, rd[3:1], 1'b0});
        apb(1'b0, ctb_pkg::ADDR_CONTROL, 8'h00);
        chk("window", 32'h06, rd);
        apb(1'b1, ctb_pkg::ADDR_CONTROL, 8'h00);
        $display("frame test done");
    endtask
    task automatic t_abort();
        result <= 2'h1;
        apb(1'b1, 12'h040, 8'h08);
        poll(5, 1'b1);
        chk("lost", 32'h28, rd);
        apb(1'b1, 12'h040, 8'h00);
        apb(1'b0, 12'h040, 8'h00);
        chk("abort", 32'h60, rd);
        result <= 2'h2;
        apb(1'b1, 12'h040, 8'h08);
        apb(1'b0, 12'h040, 8'h00);
        chk("requeue", 32'h08, rd);
        poll(4, 1'b1);
        chk("buserr", 32'h18, rd);
        apb(1'b1, ctb_pkg::ADDR_CONTROL, 8'h10);
        apb(1'b0, 12'h040, 8'h00);
        chk("abortall", 32'h50, rd);
        apb(1'b1, ctb_pkg::ADDR_CONTROL, 8'h00);
        apb(1'b0, 12'h100, 8'h00);
        chk("unmapped", 32'h1, {31'h0, se});
        $display("abort test done");
    endtask
    // Error counts are pushed through each threshold; bus-off comes last.
    task automatic t_count(input logic [3:0] add, input int n, input logic [7:0] rx,
                           input logic [7:0] cs, input logic [7:0] tec);
        {tec_add_in, rx_err_count_in} <= {add, rx};
        repeat (n) @(posedge clock_in);
        tec_add_in <= 4'h0;
        apb(1'b0, ctb_pkg::ADDR_COMM, 8'h00);
        chk("comm", {24'h0, cs}, rd);
        apb(1'b0, ctb_pkg::ADDR_TEC, 8'h00);
        chk("tec", {24'h0, tec}, rd);
    endtask
    // Bus-off recovery needs exactly 128 recessive runs; one short must not clear.
    task automatic t_recover();
        recessive_run_in <= 1'b1;
        repeat (127) @(posedge clock_in);
        recessive_run_in <= 1'b0;
        t_count(4'h0, 1, 8'h00, 8'h30, 8'h00);
        recessive_run_in <= 1'b1;
        @(posedge clock_in);
        recessive_run_in <= 1'b0;
        t_count(4'h0, 1, 8'h00, 8'h00, 8'h00);
        $display("recovery test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(posedge clock_in);
        t_count(4'h0, 1, 8'h00, 8'h00, 8'h00);
        t_frame();
        t_abort();
        {rx0_overflow_in, rx1_overflow_in} <= 2'h3;
        @(posedge clock_in);
        {rx0_overflow_in, rx1_overflow_in} <= 2'h0;
        t_count(4'hc, 8, 8'h00, 8'hc5, 8'h60);
        apb(1'b1, ctb_pkg::ADDR_COMM, 8'h00);
        t_count(4'h8, 4, 8'h80, 8'h18, 8'h80);
        t_count(4'h0, 1, 8'h60, 8'h13, 8'h80);
        tec_dec_in <= 1'b1;
        @(posedge clock_in);
        tec_dec_in <= 1'b0;
        t_count(4'h0, 1, 8'h60, 8'h07, 8'h7f);
        t_count(4'h8, 17, 8'h00, 8'h30, 8'h00);
        $display("count test done");
        t_recover();
        close_out();
    end
endmodule
`default_nettype wire
